// ===== pid_process_regulator.sv
// Purpose: Closed-loop process regulator forming a frequency command
// Assumes: Sources in 1/8192 of full scale, synchronous to i_clk
// Notes:   Loop math runs once per control tick; registers on plain port
// Behaviour
// RL1 - Target taken from selected source, default voltage
// RL2 - Regulator acts only when frequency source is 6
// RL3 - Feedback taken from selected source, default current
// RL4 - Stored keypad target 0.0-100.0%, default 50.0
// RL5 - Mode selects enable, derivative input, direction
// RL6 - Feedback multiplied by gain 0.00-10.00
// RL7 - Proportional gain 0.0-10.0 applied to error
// RL8 - Error integrated with integral time 0.0-100.0s
// RL9 - Derivative time 0.00-10.00s, zero disables
// RL10 - Signed offset 0-109% added to output
// RL11 - First-order output lag 0.0-2.5s, zero bypasses
// RL12 - Loss mode: off, flag only, flag and stop
// RL13 - Loss when feedback below detection level
// RL14 - Loss declared after persisting for delay
// RL15 - Integral clamped to 0-109% limit
// RL16 - Integral zeroed after feedback equals target long enough
// RL17 - Equal means error within margin in 1/8192 units
// RL18 - Sleep after command below level for delay
// RL19 - Wake after command above level for delay
// RL20 - Full feedback displays as maximum setting
// RL21 - Zero feedback displays as minimum setting
// RL22 - Asleep holds output zero, loop keeps running
// RL23 - Loss flag set on loss, cleared on recovery
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pid_process_regulator #(
    parameter int TICK_CYCLES = pid_pkg::TICK_CYC
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire logic [pid_pkg::AW-1:0]  i_addr,
    input  wire logic [15:0]             i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    input  wire pid_pkg::src_t           i_src,
    output logic      [15:0]             o_rdata,
    output logic      [15:0]             o_freq,
    output logic      [15:0]             o_disp,
    output logic                         o_active,
    output logic                         o_sleep,
    output logic                         o_loss,
    output logic                         o_stop
);
    import pid_pkg::*;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    logic [15:0]      cfg_q [NREG];
    logic [21:0]      tick_cnt_q;
    logic             tick_q;
    logic signed [31:0] integ_q;
    logic signed [31:0] dprev_q;
    logic [15:0]      y_q;
    logic [15:0]      eq_cnt_q;
    logic [15:0]      loss_cnt_q;
    logic [15:0]      slp_cnt_q;
    logic [15:0]      wake_cnt_q;
    sleep_st_t        st_q;
    sleep_st_t        st_d;

    int  tgt_c;
    int  fb_raw_c;
    int  fb_c;
    int  err_c;
    int  p_c;
    int  i_c;
    int  d_c;
    int  dsrc_c;
    int  off_c;
    int  sum_c;
    int  y_c;
    int  lim_c;
    int  cmd_c;
    int  disp_c;
    logic active_c;
    logic low_c;
    logic equal_c;
    logic zero_hit_c;
    logic rev_c;
    logic fbd_c;

    logic [2:0]  mode;
    logic [1:0]  loss_mode;
    logic [15:0] ti;
    logic [15:0] lag;
    assign mode      = cfg_q[R_MODE][2:0];
    assign loss_mode = cfg_q[R_LOSS_MODE][1:0];
    assign ti        = cfg_q[R_TI];
    assign lag       = cfg_q[R_LAG];

    // Register file, one write decoder per entry
    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_cfg
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    cfg_q[g] <= RST_VAL[g];
                end else if (i_wr && i_addr == AW'(g)) begin
                    cfg_q[g] <= i_wdata;
                end
            end
        end
    endgenerate

    // Read data stands for one cycle only; unmapped reads give zero
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_rd) begin
            o_rdata <= 16'h0000;
        end else if (int'(i_addr) < NREG) begin
            o_rdata <= cfg_q[i_addr];
        end else begin
            unique case (i_addr)
                R_STATUS: o_rdata <= {12'h000, o_stop, o_loss, o_sleep, o_active};
                R_DISP:   o_rdata <= o_disp;
                R_FREQ:   o_rdata <= o_freq;
                default:  o_rdata <= 16'h0000;
            endcase
        end
    end

    // Control tick divider
    always_ff @(posedge i_clk) begin
        if (i_rst || tick_cnt_q == 22'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= 22'h000000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 22'h000001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == 22'(TICK_CYCLES - 1));
        end
    end

    // Target and feedback selection
    always_comb begin
        unique case (cfg_q[R_TGT_SEL][2:0])
            SRC_POT:  tgt_c = int'(i_src.pot); // RL1
            SRC_CURR: tgt_c = int'(i_src.curr);
            SRC_COMM: tgt_c = int'(i_src.comm);
            SRC_KEY:  tgt_c = int'(cfg_q[R_KEY_TGT]) * FULL / KEY_DIV; // RL4
            default:  tgt_c = int'(i_src.volt);
        endcase
        unique case (cfg_q[R_FB_SEL][2:0])
            SRC_POT:  fb_raw_c = int'(i_src.pot); // RL3
            SRC_VOLT: fb_raw_c = int'(i_src.volt);
            SRC_COMM: fb_raw_c = int'(i_src.comm);
            default:  fb_raw_c = int'(i_src.curr);
        endcase
    end

    // Regulator arithmetic
    always_comb begin
        active_c = (mode != MODE_OFF) && (mode <= MODE_FB_REV)
                 && (cfg_q[R_FREQ_SRC] == FREQ_SRC_PID); // RL2 RL5
        rev_c    = (mode == 3'h3) || (mode == MODE_FB_REV); // RL5
        fbd_c    = (mode == 3'h2) || (mode == MODE_FB_REV);
        fb_c     = fb_raw_c * int'(cfg_q[R_FB_GAIN]) / GAIN_DIV; // RL6
        err_c    = rev_c ? fb_c - tgt_c : tgt_c - fb_c;
        p_c      = err_c * int'(cfg_q[R_KP]) / KP_DIV; // RL7
        lim_c    = int'(cfg_q[R_I_CLAMP]) * FULL / PCT_DIV;
        equal_c  = (err_c <= int'(cfg_q[R_EQ_MARGIN]))
                 && (-err_c <= int'(cfg_q[R_EQ_MARGIN])); // RL17
        zero_hit_c = (cfg_q[R_I_ZERO] != 16'h0000) && equal_c
                   && (int'(eq_cnt_q) + 1 >= int'(cfg_q[R_I_ZERO]) * TICKS_PER_S); // RL16
        // Integral time of zero freezes the accumulator rather than dividing by zero
        if (zero_hit_c) begin
            i_c = 0; // RL16
        end else if (ti == 16'h0000) begin
            i_c = integ_q;
        end else begin
            i_c = integ_q + err_c / int'(ti); // RL8
        end
        if (i_c > lim_c) begin
            i_c = lim_c; // RL15
        end else if (i_c < -lim_c) begin
            i_c = -lim_c;
        end
        if (fbd_c) begin
            dsrc_c = rev_c ? fb_c : -fb_c;
        end else begin
            dsrc_c = err_c;
        end
        d_c   = (dsrc_c - dprev_q) * int'(cfg_q[R_TD]) / TD_DIV; // RL9
        off_c = int'(cfg_q[R_OFF_AMT]) * FULL / PCT_DIV;
        if (cfg_q[R_OFF_POL][0]) begin
            off_c = -off_c; // RL10
        end
        sum_c = p_c + i_c + d_c + off_c;
        if (sum_c < 0) begin
            sum_c = 0;
        end else if (sum_c > FULL - 1) begin
            sum_c = FULL - 1;
        end
        // Lag step uses (x - y) / (T/dt + 1), backward-Euler first order at tick rate, quotient truncated toward zero
        if (lag == 16'h0000) begin
            y_c = sum_c; // RL11
        end else begin
            y_c = int'(y_q) + (sum_c - int'(y_q)) / (int'(lag) + 1);
        end
        cmd_c  = y_c * int'(cfg_q[R_MAX_FREQ]) / FULL;
        low_c  = fb_raw_c < int'(cfg_q[R_LOSS_LVL]) * FULL / PCT_DIV; // RL13
        disp_c = int'(cfg_q[R_DISP_MIN])
               + (int'(cfg_q[R_DISP_MAX]) - int'(cfg_q[R_DISP_MIN])) * fb_raw_c / FULL; // RL20 RL21
    end

    // Loop state, cleared at once whenever the regulator is not in charge
    always_ff @(posedge i_clk) begin
        if (i_rst || !active_c) begin
            integ_q <= 32'sh00000000;
            dprev_q <= 32'sh00000000;
            y_q     <= 16'h0000;
        end else if (tick_q) begin
            integ_q <= i_c; // RL8
            dprev_q <= dsrc_c;
            y_q     <= 16'(y_c);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || !active_c) begin
            eq_cnt_q <= 16'h0000;
        end else if (tick_q) begin
            if (!equal_c || zero_hit_c) begin
                eq_cnt_q <= 16'h0000; // RL16
            end else if (eq_cnt_q != 16'hFFFF) begin
                eq_cnt_q <= eq_cnt_q + 16'h0001;
            end
        end
    end

    // Feedback loss detection
    always_ff @(posedge i_clk) begin
        if (i_rst || loss_mode == 2'h0) begin
            loss_cnt_q <= 16'h0000; // RL12
            o_loss     <= 1'b0;
            o_stop     <= 1'b0;
        end else if (tick_q) begin
            if (low_c) begin
                if (loss_cnt_q != 16'hFFFF) begin
                    loss_cnt_q <= loss_cnt_q + 16'h0001;
                end
                if (int'(loss_cnt_q) + 1 >= int'(cfg_q[R_LOSS_DLY])) begin
                    o_loss <= 1'b1; // RL14 RL23
                    o_stop <= (loss_mode == LOSS_STOP); // RL12
                end
            end else begin
                loss_cnt_q <= 16'h0000;
                o_loss     <= 1'b0; // RL23
                o_stop     <= 1'b0;
            end
        end
    end

    // Sleep and wake, judged on the command the loop would give
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_RUN: begin
                if (cmd_c < int'(cfg_q[R_SLP_LVL])
                    && int'(slp_cnt_q) + 1 >= int'(cfg_q[R_SLP_DLY])) begin
                    st_d = ST_SLEEP; // RL18
                end
            end
            ST_SLEEP: begin
                if (cmd_c > int'(cfg_q[R_WAKE_LVL])
                    && int'(wake_cnt_q) + 1 >= int'(cfg_q[R_WAKE_DLY])) begin
                    st_d = ST_RUN; // RL19
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || !active_c) begin
            st_q       <= ST_RUN;
            slp_cnt_q  <= 16'h0000;
            wake_cnt_q <= 16'h0000;
        end else if (tick_q) begin
            st_q <= st_d;
            if (st_q == ST_RUN && cmd_c < int'(cfg_q[R_SLP_LVL]) && st_d == ST_RUN) begin
                slp_cnt_q <= slp_cnt_q + 16'h0001; // RL18
            end else begin
                slp_cnt_q <= 16'h0000;
            end
            if (st_q == ST_SLEEP && cmd_c > int'(cfg_q[R_WAKE_LVL]) && st_d == ST_SLEEP) begin
                wake_cnt_q <= wake_cnt_q + 16'h0001; // RL19
            end else begin
                wake_cnt_q <= 16'h0000;
            end
        end
    end

    // Outputs
    always_ff @(posedge i_clk) begin
        if (i_rst || !active_c) begin
            o_freq   <= 16'h0000;
            o_active <= 1'b0;
            o_sleep  <= 1'b0;
        end else if (tick_q) begin
            o_freq   <= (st_d == ST_SLEEP) ? 16'h0000 : 16'(cmd_c); // RL22
            o_active <= 1'b1;
            o_sleep  <= (st_d == ST_SLEEP);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_disp <= 16'h0000;
        end else if (tick_q) begin
            o_disp <= 16'(disp_c); // RL20 RL21
        end
    end

    // Checks
    a_read_idle_zero: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data outside read slot");
    a_inactive_freq_zero: assert property ( // RL2
        cfg_q[R_FREQ_SRC] != FREQ_SRC_PID |=> !o_active && o_freq == 16'h0000)
        else $error("regulator active without closed-loop source");
    a_sleep_holds_zero: assert property (o_sleep |-> o_freq == 16'h0000) // RL22
        else $error("output nonzero while asleep");
    a_stop_needs_loss: assert property (o_stop |-> o_loss) // RL12
        else $error("stop without loss flag");
    a_loss_mode_off: assert property (loss_mode == 2'h0 |=> !o_loss && !o_stop) // RL12
        else $error("loss flag while detection disabled");
    a_loss_recover: assert property ( // RL23
        tick_q && !low_c && loss_mode != 2'h0 |=> !o_loss)
        else $error("loss flag kept after recovery");
    a_loss_immediate: assert property ( // RL14
        tick_q && low_c && loss_mode != 2'h0 && cfg_q[R_LOSS_DLY] == 16'h0000 |=> o_loss)
        else $error("loss not declared with zero delay");
    a_integ_clamp: assert property ( // RL15
        tick_q && active_c && !i_wr |=> integ_q <= $past(lim_c) && integ_q >= -$past(lim_c))
        else $error("integral outside clamp");
    a_integ_frozen: assert property ( // RL8
        tick_q && active_c && ti == 16'h0000 && !zero_hit_c && integ_q <= lim_c
        && integ_q >= -lim_c |=> integ_q == $past(integ_q))
        else $error("integral moved with zero integral time");
    a_integ_zeroed: assert property (tick_q && active_c && zero_hit_c |=> integ_q == 0) // RL16
        else $error("integral not reset at equality");
    a_lag_bypass: assert property ( // RL11
        tick_q && active_c && lag == 16'h0000 |=> int'(y_q) == $past(sum_c))
        else $error("lag filter active at zero time");
    a_active_on_tick: assert property (tick_q && active_c |=> o_active) // RL2 RL5
        else $error("regulator in charge but not flagged active");
    // Flag edges must trace back to the condition seen at the deciding tick
    a_loss_needs_low: assert property ($rose(o_loss) |-> $past(low_c)) // RL13
        else $error("loss flag raised while feedback above level");
    a_stop_mode_two: assert property ($rose(o_stop) |-> $past(loss_mode) == LOSS_STOP) // RL12
        else $error("stop raised outside stop mode");
    a_sleep_below_level: assert property ( // RL18
        $rose(o_sleep) |-> $past(cmd_c) < $past(int'(cfg_q[R_SLP_LVL])))
        else $error("sleep entered with command above sleep level");
    // Deactivation also drops the sleep flag, so only an active drop is a wake
    a_wake_above_level: assert property ( // RL19
        $fell(o_sleep) && o_active |-> $past(cmd_c) > $past(int'(cfg_q[R_WAKE_LVL])))
        else $error("wake with command below wake level");

    c_enter_sleep: cover property (!o_sleep ##1 o_sleep);
    c_loss_stop: cover property (o_stop);
    c_integ_reset: cover property (tick_q && active_c && zero_hit_c);
    c_wake_up: cover property (o_sleep ##1 !o_sleep && o_active);
    c_lag_filter: cover property (tick_q && active_c && lag != 16'h0000);

endmodule // pid_process_regulator
`default_nettype wire

// ===== pid_pkg.sv
// Purpose: Shared constants and types for the process regulator
// Assumes: Signals in 1/8192 of full scale, one 100 ms control tick
// Notes:   Register index is the address on the plain register port
`default_nettype none
package pid_pkg;
    localparam int NREG = 25;
    localparam int AW   = 5;
    localparam logic [AW-1:0] R_TGT_SEL   = 5'h00;
    localparam logic [AW-1:0] R_FB_SEL    = 5'h01;
    localparam logic [AW-1:0] R_KEY_TGT   = 5'h02;
    localparam logic [AW-1:0] R_MODE      = 5'h03;
    localparam logic [AW-1:0] R_FB_GAIN   = 5'h04;
    localparam logic [AW-1:0] R_KP        = 5'h05;
    localparam logic [AW-1:0] R_TI        = 5'h06;
    localparam logic [AW-1:0] R_TD        = 5'h07;
    localparam logic [AW-1:0] R_OFF_POL   = 5'h08;
    localparam logic [AW-1:0] R_OFF_AMT   = 5'h09;
    localparam logic [AW-1:0] R_LAG       = 5'h0A;
    localparam logic [AW-1:0] R_LOSS_MODE = 5'h0B;
    localparam logic [AW-1:0] R_LOSS_LVL  = 5'h0C;
    localparam logic [AW-1:0] R_LOSS_DLY  = 5'h0D;
    localparam logic [AW-1:0] R_I_CLAMP   = 5'h0E;
    localparam logic [AW-1:0] R_I_ZERO    = 5'h0F;
    localparam logic [AW-1:0] R_EQ_MARGIN = 5'h10;
    localparam logic [AW-1:0] R_SLP_LVL   = 5'h11;
    localparam logic [AW-1:0] R_SLP_DLY   = 5'h12;
    localparam logic [AW-1:0] R_WAKE_LVL  = 5'h13;
    localparam logic [AW-1:0] R_WAKE_DLY  = 5'h14;
    localparam logic [AW-1:0] R_DISP_MAX  = 5'h15;
    localparam logic [AW-1:0] R_DISP_MIN  = 5'h16;
    localparam logic [AW-1:0] R_FREQ_SRC  = 5'h17;
    localparam logic [AW-1:0] R_MAX_FREQ  = 5'h18;
    localparam logic [AW-1:0] R_STATUS    = 5'h19;
    localparam logic [AW-1:0] R_DISP      = 5'h1A;
    localparam logic [AW-1:0] R_FREQ      = 5'h1B;
    localparam logic [15:0] RST_VAL [NREG] = '{
        16'h0001, 16'h0002, 16'h01F4, 16'h0000, 16'h0064, 16'h000A,
        16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h000A, 16'h0064, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h0000,
        16'h1770};
    localparam logic [2:0] SRC_POT  = 3'h0;
    localparam logic [2:0] SRC_VOLT = 3'h1;
    localparam logic [2:0] SRC_CURR = 3'h2;
    localparam logic [2:0] SRC_COMM = 3'h3;
    localparam logic [2:0] SRC_KEY  = 3'h4;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_FB_REV = 3'h4;
    localparam logic [1:0] LOSS_STOP = 2'h2;
    localparam logic [15:0] FREQ_SRC_PID = 16'h0006;
    localparam int FULL = 8192;
    localparam int PCT_DIV = 100;
    localparam int GAIN_DIV = 100;
    localparam int KP_DIV = 10;
    localparam int KEY_DIV = 1000;
    localparam int TD_DIV = 10;
    localparam int TICKS_PER_S = 10;
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    typedef struct packed {
        logic [15:0] pot;
        logic [15:0] volt;
        logic [15:0] curr;
        logic [15:0] comm;
    } src_t;
    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_SLEEP = 1'b1
    } sleep_st_t;
endpackage
`default_nettype wire

// ===== fb_source_model.sv
// Purpose: Process transducer and setpoint sources feeding the regulator
// Assumes: Values in 1/8192 of full scale, sampled on i_clk
// Notes:   One cycle of converter latency; i_slow holds each sample 4 cycles
//          to mimic a sluggish converter, so the loop must not rely on speed
`timescale 1ns/1ps
`default_nettype none
module fb_source_model (
    input  wire logic           i_clk,
    input  wire pid_pkg::src_t  i_set,
    input  wire logic           i_slow,
    output var  pid_pkg::src_t  o_src
);
    import pid_pkg::*;
    logic [1:0] div_q = 2'h0;
    always_ff @(posedge i_clk) begin
        div_q <= div_q + 2'h1;
        if (!i_slow || div_q == 2'h0) begin
            o_src <= i_set;
        end
    end
endmodule // fb_source_model
`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for the process regulator
// Assumes: TICK_CYCLES of 8, all results read back over the register port
// Notes:   Derivative and lag are judged in steady state only, not mid-transient
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pid_pkg::*;
    logic          i_clk = 1'b0;
    logic          i_rst = 1'b1;
    logic [AW-1:0] i_addr = '0;
    logic [15:0]   i_wdata = '0;
    logic          i_wr = 1'b0;
    logic          i_rd = 1'b0;
    logic          slow = 1'b0;
    src_t          set_q = '0;
    src_t          src;
    logic [15:0]   o_rdata;
    logic          rd_q = 1'b0;
    logic [15:0]   e;
    logic [15:0]   exp_q[$];
    int            miscompares = 0;
    int            n_compared = 0;
    int            v[4];
    int            g, mn, mx, t, f;
    always #20 i_clk = ~i_clk;
    fb_source_model i_fb_source_model (.i_clk(i_clk), .i_set(set_q), .i_slow(slow), .o_src(src));
    pid_process_regulator #(.TICK_CYCLES(8)) i_pid_process_regulator (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .i_src(src), .o_rdata(o_rdata), .o_freq(), .o_disp(), .o_active(),
        .o_sleep(), .o_loss(), .o_stop());
    always @(posedge i_clk) begin
        rd_q <= i_rd;
        if (rd_q) begin
            n_compared++;
            e = exp_q.size() != 0 ? exp_q.pop_front() : 16'hXXXX;
            if (o_rdata !== e) begin
                miscompares++;
                $display("unexpected at %0t: read %h, wanted %h", $time, o_rdata, e);
            end
        end
    end
    function automatic logic [15:0] cmd(input int d);
        int c;
        c = d < 0 ? 0 : (d > 8191 ? 8191 : d);
        return 16'(c * 6000 / 8192);
    endfunction
    task automatic wr(input int a, input int d);
        @(posedge i_clk);
        i_addr <= AW'(a);
        i_wdata <= 16'(d);
        i_rd <= 1'b0;
        i_wr <= 1'b1;
    endtask
    task automatic rd(input int a, input logic [15:0] x);
        @(posedge i_clk);
        i_addr <= AW'(a);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        exp_q.push_back(x);
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge i_clk);
            i_wr <= 1'b0;
            i_rd <= 1'b0;
        end
    endtask
    task automatic curr(input int c);
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        slow <= 1'b0;
        set_q <= {16'h0000, 16'h0000, 16'(c), 16'h0000};
    endtask
    task automatic report_and_stop;
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        $display("unexpected at %0t: run did not finish", $time);
        report_and_stop;
    end
    initial begin
        void'($urandom(32'hF184904D));
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < NREG; i++) rd(i, RST_VAL[i]);
        wr(R_STATUS, 16'hFFFF);
        rd(R_STATUS, 16'h0000);
        rd(28, 16'h0000);
        g = $urandom_range(999);
        wr(R_DISP_MIN, g);
        rd(R_DISP_MIN, 16'(g));
        idle(2);
        $display("test registers done");
        wr(R_KEY_TGT, 250);
        wr(R_TI, 0);
        curr(1024);
        wr(R_MODE, 1);
        idle(40);
        rd(R_STATUS, 16'h0000);
        rd(R_FREQ, 16'h0000);
        wr(R_TGT_SEL, 4);
        wr(R_FREQ_SRC, 6);
        for (int m = 0; m < 6; m++) begin
            wr(R_MODE, m);
            idle(40);
            rd(R_FREQ, (m == 1 || m == 2) ? cmd(1024) : 16'h0000);
            rd(R_STATUS, 16'(m >= 1 && m <= 4));
        end
        wr(R_MODE, 1);
        $display("test modes done");
        for (int ts = 0; ts < 6; ts++) begin
            for (int fs = 0; fs < 5; fs++) begin
                for (int k = 0; k < 4; k++) v[k] = $urandom_range(8191);
                g = $urandom_range(1000);
                mn = $urandom_range(500);
                mx = mn + $urandom_range(499);
                set_q <= {16'(v[0]), 16'(v[1]), 16'(v[2]), 16'(v[3])};
                slow <= 1'($urandom_range(1));
                wr(R_TGT_SEL, ts);
                wr(R_FB_SEL, fs);
                wr(R_FB_GAIN, g);
                wr(R_DISP_MAX, mx);
                wr(R_DISP_MIN, mn);
                idle(40);
                t = ts == 4 ? 2048 : v[ts == 5 ? 1 : ts];
                f = v[fs == 4 ? 2 : fs];
                rd(R_FREQ, cmd(t - f * g / 100));
                rd(R_DISP, 16'(mn + (mx - mn) * f / 8192));
            end
        end
        wr(R_TGT_SEL, 4);
        wr(R_FB_SEL, 2);
        wr(R_FB_GAIN, 100);
        $display("test sources done");
        curr(2048);
        wr(R_OFF_AMT, 25);
        idle(40);
        rd(R_FREQ, cmd(2048));
        wr(R_OFF_POL, 1);
        idle(40);
        rd(R_FREQ, 16'h0000);
        wr(R_OFF_POL, 0);
        wr(R_OFF_AMT, 109);
        idle(40);
        rd(R_FREQ, cmd(8929));
        wr(R_OFF_AMT, 0);
        $display("test offset done");
        curr(6000);
        wr(R_LOSS_LVL, 50);
        wr(R_LOSS_DLY, 3);
        wr(R_LOSS_MODE, 2);
        idle(40);
        curr(100);
        idle(12);
        rd(R_STATUS, 16'h0001);
        idle(30);
        rd(R_STATUS, 16'h000D);
        wr(R_LOSS_MODE, 1);
        idle(20);
        rd(R_STATUS, 16'h0005);
        curr(6000);
        idle(40);
        rd(R_STATUS, 16'h0001);
        curr(100);
        wr(R_LOSS_MODE, 0);
        idle(40);
        rd(R_STATUS, 16'h0001);
        wr(R_LOSS_DLY, 0);
        wr(R_LOSS_MODE, 1);
        idle(12);
        rd(R_STATUS, 16'h0005);
        wr(R_LOSS_MODE, 0);
        $display("test loss done");
        curr(0);
        wr(R_SLP_LVL, 2000);
        wr(R_SLP_DLY, 2);
        wr(R_WAKE_LVL, 5000);
        wr(R_WAKE_DLY, 2);
        idle(40);
        rd(R_FREQ, 16'h0000);
        rd(R_STATUS, 16'h0003);
        wr(R_KEY_TGT, 1000);
        idle(40);
        rd(R_FREQ, cmd(8192));
        rd(R_STATUS, 16'h0001);
        wr(R_SLP_LVL, 0);
        $display("test sleep done");
        wr(R_KEY_TGT, 250);
        wr(R_KP, 0);
        wr(R_I_CLAMP, 25);
        wr(R_TI, 1);
        idle(40);
        rd(R_FREQ, cmd(2048));
        wr(R_I_CLAMP, 10);
        idle(40);
        rd(R_FREQ, cmd(819));
        wr(R_EQ_MARGIN, 5);
        wr(R_I_ZERO, 1);
        curr(2048);
        idle(40);
        rd(R_FREQ, cmd(819));
        idle(80);
        rd(R_FREQ, 16'h0000);
        idle(4);
        $display("test integral done");
        wr(R_KP, 10);
        wr(R_TD, 100);
        curr(1024);
        idle(40);
        rd(R_FREQ, cmd(1024 + 819));
        wr(R_TD, 0);
        wr(R_TI, 0);
        wr(R_LAG, 1);
        wr(R_MODE, 0);
        wr(R_MODE, 1);
        curr(0);
        // Rounding toward zero leaves the filter one count short of its input
        idle(120);
        rd(R_FREQ, cmd(2047));
        idle(4);
        $display("test derivative and lag done");
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
